/* inc/csbu_pkg.sv */
package csbu_pkg;
   localparam int unsigned FLAG_C = 0;
   localparam int unsigned FLAG_Z = 1;
   localparam int unsigned FLAG_N = 2;
   localparam int unsigned FLAG_V = 3;
   localparam int unsigned FLAG_S = 4;
   localparam int unsigned FLAG_H = 5;
   localparam int unsigned PC_W   = 16;
   localparam logic [15:0] PC_STEP_ONE   = 16'h0001;
   localparam logic [15:0] PC_STEP_SHORT = 16'h0002;
   localparam logic [15:0] PC_STEP_LONG  = 16'h0003;
   localparam logic [15:0] PC_RESET      = 16'h0000;
   localparam logic [7:0]  FLAGS_RESET   = 8'h00;

   typedef enum logic [3:0]
   {
      CSBU_OP_NONE       = 4'h0,
      CSBU_OP_CMP_IMM    = 4'h1,
      CSBU_OP_CMP_SKIP   = 4'h2,
      CSBU_OP_SKIP_RBC   = 4'h3,
      CSBU_OP_SKIP_RBS   = 4'h4,
      CSBU_OP_SKIP_IOBC  = 4'h5,
      CSBU_OP_SKIP_IOBS  = 4'h6,
      CSBU_OP_BR_SET     = 4'h7,
      CSBU_OP_BR_CLR     = 4'h8,
      CSBU_OP_BR_EQ      = 4'h9,
      CSBU_OP_BR_NE      = 4'hA,
      CSBU_OP_BR_CS      = 4'hB,
      CSBU_OP_BR_SH      = 4'hC,
      CSBU_OP_BR_MI      = 4'hD,
      CSBU_OP_BR_PL      = 4'hE
   } csbu_op_t;
endpackage

/* verilog/csbu_unit.sv */
`timescale 1ns/1ps
module csbu_unit
   import csbu_pkg::*;
(
   input  wire logic        clk_i,         // Core clock
   input  wire logic        rst_i,         // Synchronous reset, high
   input  wire logic        exec_i,        // Instruction valid this cycle
   input  wire logic [3:0]  op_i,          // Decoded operation
   input  wire logic [7:0]  reg_a_i,       // First working register value
   input  wire logic [7:0]  reg_b_i,       // Second register or immediate
   input  wire logic [7:0]  io_val_i,      // Addressed I/O register value
   input  wire logic [2:0]  bit_sel_i,     // Bit or flag select
   input  wire logic [6:0]  offset_i,      // Signed branch offset
   input  wire logic        next_long_i,   // Following instruction is two words
   input  wire logic [7:0]  flags_load_i,  // Flags value from elsewhere
   input  wire logic        flags_we_i,    // Load flags from outside
   output logic [15:0]      pc_o,          // Program counter
   output logic [7:0]       flags_o,       // Processor flags register
   output logic             taken_o        // Last instruction skipped or branched
);
   logic [15:0] pc;
   logic [7:0]  flags;
   logic        taken;
   logic [8:0]  diff;
   logic [4:0]  hdiff;
   logic        cond;
   logic        is_skip;
   logic        is_br;
   logic [15:0] next_pc;
   logic [7:0]  next_flags;
   csbu_op_t    op;

   assign op = csbu_op_t'(op_i);
   assign diff  = {1'b0, reg_a_i} - {1'b0, reg_b_i};
   assign hdiff = {1'b0, reg_a_i[3:0]} - {1'b0, reg_b_i[3:0]};

   always_comb
   begin
      cond    = 1'b0;
      is_skip = 1'b0;
      is_br   = 1'b0;
      case (op)
         CSBU_OP_CMP_SKIP:
         begin
            is_skip = 1'b1;
            cond    = (reg_a_i == reg_b_i);
         end
         CSBU_OP_SKIP_RBC:
         begin
            is_skip = 1'b1;
            cond    = ~reg_a_i[bit_sel_i];
         end
         CSBU_OP_SKIP_RBS:
         begin
            is_skip = 1'b1;
            cond    = reg_a_i[bit_sel_i];
         end
         CSBU_OP_SKIP_IOBC:
         begin
            is_skip = 1'b1;
            cond    = ~io_val_i[bit_sel_i];
         end
         CSBU_OP_SKIP_IOBS:
         begin
            is_skip = 1'b1;
            cond    = io_val_i[bit_sel_i];
         end
         CSBU_OP_BR_SET:
         begin
            is_br = 1'b1;
            cond  = flags[bit_sel_i];
         end
         CSBU_OP_BR_CLR:
         begin
            is_br = 1'b1;
            cond  = ~flags[bit_sel_i];
         end
         CSBU_OP_BR_EQ:
         begin
            is_br = 1'b1;
            cond  = flags[FLAG_Z];
         end
         CSBU_OP_BR_NE:
         begin
            is_br = 1'b1;
            cond  = ~flags[FLAG_Z];
         end
         CSBU_OP_BR_CS:
         begin
            is_br = 1'b1;
            cond  = flags[FLAG_C];
         end
         CSBU_OP_BR_SH:
         begin
            is_br = 1'b1;
            cond  = ~flags[FLAG_C];
         end
         CSBU_OP_BR_MI:
         begin
            is_br = 1'b1;
            cond  = flags[FLAG_N];
         end
         CSBU_OP_BR_PL:
         begin
            is_br = 1'b1;
            cond  = ~flags[FLAG_N];
         end
         default:
         begin
            cond = 1'b0;
         end
      endcase
   end

   always_comb
   begin
      next_pc = pc + PC_STEP_ONE;
      if (is_skip && cond)
      begin
         next_pc = pc + (next_long_i ? PC_STEP_LONG : PC_STEP_SHORT);
      end
      else if (is_br && cond)
      begin
         // Offset is sign-extended; wraps modulo the counter width
         next_pc = pc + {{9{offset_i[6]}}, offset_i} + PC_STEP_ONE;
      end
   end

   always_comb
   begin
      next_flags = flags;
      if (op == CSBU_OP_CMP_IMM)
      begin
         next_flags[FLAG_Z] = (diff[7:0] == 8'h00);
         next_flags[FLAG_N] = diff[7];
         next_flags[FLAG_C] = diff[8];
         next_flags[FLAG_H] = hdiff[4];
         next_flags[FLAG_V] = (reg_a_i[7] ^ reg_b_i[7]) & (reg_a_i[7] ^ diff[7]);
         next_flags[FLAG_S] = diff[7] ^ next_flags[FLAG_V];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pc <= PC_RESET;
      else if (exec_i)
         pc <= next_pc;
   end

   // External load loses to a compare in the same cycle: the compare is the newer result
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         flags <= FLAGS_RESET;
      else if (exec_i && op == CSBU_OP_CMP_IMM)
         flags <= next_flags;
      else if (flags_we_i)
         flags <= flags_load_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         taken <= 1'b0;
      else if (exec_i)
         taken <= (is_skip | is_br) & cond;
   end

   assign pc_o    = pc;
   assign flags_o = flags;
   assign taken_o = taken;

   a_cmp_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      exec_i && op == CSBU_OP_CMP_IMM |=> flags[FLAG_Z] == ($past(reg_a_i) == $past(reg_b_i)))
      else $error("compare zero flag wrong");
   a_cmp_carry: assert property (@(posedge clk_i) disable iff (rst_i)
      exec_i && op == CSBU_OP_CMP_IMM |=> flags[FLAG_C] == ($past(reg_a_i) < $past(reg_b_i)))
      else $error("compare carry flag wrong");
   a_skip_eq: assert property (@(posedge clk_i) disable iff (rst_i)
      exec_i && op == CSBU_OP_CMP_SKIP && reg_a_i == reg_b_i && !next_long_i && !flags_we_i
      |=> pc == $past(pc) + PC_STEP_SHORT && flags == $past(flags))
      else $error("equal skip wrong");
   a_skip_rbc: assert property (@(posedge clk_i) disable iff (rst_i)
      exec_i && op == CSBU_OP_SKIP_RBC && !reg_a_i[bit_sel_i] && next_long_i
      |=> pc == $past(pc) + PC_STEP_LONG)
      else $error("register bit clear skip wrong");
   a_skip_rbs: assert property (@(posedge clk_i) disable iff (rst_i)
      exec_i && op == CSBU_OP_SKIP_RBS && !reg_a_i[bit_sel_i] |=> pc == $past(pc) + PC_STEP_ONE)
      else $error("register bit set skip wrong");
   a_skip_iobc: assert property (@(posedge clk_i) disable iff (rst_i)
      exec_i && op == CSBU_OP_SKIP_IOBC && !io_val_i[bit_sel_i] |=> taken)
      else $error("io bit clear skip wrong");
   a_skip_iobs: assert property (@(posedge clk_i) disable iff (rst_i)
      exec_i && op == CSBU_OP_SKIP_IOBS && io_val_i[bit_sel_i] && !next_long_i
      |=> pc == $past(pc) + PC_STEP_SHORT)
      else $error("io bit set skip wrong");
   a_branch_eq: assert property (@(posedge clk_i) disable iff (rst_i)
      exec_i && op == CSBU_OP_BR_EQ && flags[FLAG_Z]
      |=> pc == $past(pc) + {{9{$past(offset_i[6])}}, $past(offset_i)} + PC_STEP_ONE)
      else $error("equal branch target wrong");
   a_branch_sh: assert property (@(posedge clk_i) disable iff (rst_i)
      exec_i && op == CSBU_OP_BR_SH && flags[FLAG_C] |=> !taken)
      else $error("same or higher branch taken with carry");
   a_branch_flags: assert property (@(posedge clk_i) disable iff (rst_i)
      exec_i && is_br && !flags_we_i |=> flags == $past(flags))
      else $error("branch altered flags");

   c_skip_long: cover property (@(posedge clk_i) exec_i && is_skip && cond && next_long_i);
   c_branch_back: cover property (@(posedge clk_i) exec_i && is_br && cond && offset_i[6]);
   c_cmp_then_br: cover property (@(posedge clk_i)
      exec_i && op == CSBU_OP_CMP_IMM ##1 exec_i && op == CSBU_OP_BR_NE);
endmodule

/* testbench/csbu_unit_tb.sv */
`timescale 1ns/1ps
module csbu_unit_tb;
   import csbu_pkg::*;
   logic        clk_i, rst_i, exec_i, next_long_i, flags_we_i, taken_o;
   logic [3:0]  op_i;
   logic [7:0]  reg_a_i, reg_b_i, io_val_i, flags_load_i, flags_o;
   logic [2:0]  bit_sel_i;
   logic [6:0]  offset_i;
   logic [15:0] pc_o, exp_pc;
   int          n_mismatch, total_checks;

   csbu_unit csbu_unit_i (.clk_i(clk_i), .rst_i(rst_i), .exec_i(exec_i), .op_i(op_i),
      .reg_a_i(reg_a_i), .reg_b_i(reg_b_i), .io_val_i(io_val_i), .bit_sel_i(bit_sel_i),
      .offset_i(offset_i), .next_long_i(next_long_i), .flags_load_i(flags_load_i),
      .flags_we_i(flags_we_i), .pc_o(pc_o), .flags_o(flags_o), .taken_o(taken_o));

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      total_checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask

   // One instruction, then an idle edge so exec never reissues a stale op
   task automatic run(input logic [3:0] o, input logic [7:0] a, b, io, input logic [2:0] bs,
      input logic [6:0] off, input logic lg, t, input logic [15:0] step, input logic [7:0] fl);
      @(posedge clk_i);
      exec_i <= 1'b1;
      op_i <= o;
      reg_a_i <= a;
      reg_b_i <= b;
      io_val_i <= io;
      bit_sel_i <= bs;
      offset_i <= off;
      next_long_i <= lg;
      @(posedge clk_i);
      exec_i <= 1'b0;
      #1;
      exp_pc = exp_pc + step;
      chk("pc", exp_pc, pc_o);
      chk("taken", {15'h0000, t}, {15'h0000, taken_o});
      chk("flags", {8'h00, fl}, {8'h00, flags_o});
   endtask

   task automatic set_flags(input logic [7:0] v);
      @(posedge clk_i);
      flags_load_i <= v;
      flags_we_i <= 1'b1;
      @(posedge clk_i);
      flags_we_i <= 1'b0;
      #1;
      chk("flags load", {8'h00, v}, {8'h00, flags_o});
   endtask

   task automatic t_reset();
      chk("pc reset", PC_RESET, pc_o);
      chk("flags reset", {8'h00, FLAGS_RESET}, {8'h00, flags_o});
      chk("taken reset", 16'h0000, {15'h0000, taken_o});
   endtask

   task automatic t_cmp_imm();
      set_flags(8'h00);
      run(CSBU_OP_CMP_IMM, 8'h10, 8'h20, 8'h00, 3'h0, 7'h00, 1'b0, 1'b0, 16'h0001, 8'h15);
      run(CSBU_OP_CMP_IMM, 8'h35, 8'h35, 8'h00, 3'h0, 7'h00, 1'b0, 1'b0, 16'h0001, 8'h02);
      run(CSBU_OP_CMP_IMM, 8'h80, 8'h01, 8'h00, 3'h0, 7'h00, 1'b0, 1'b0, 16'h0001, 8'h38);
   endtask

   task automatic t_cmp_skip();
      set_flags(8'h2A);
      run(CSBU_OP_CMP_SKIP, 8'h5A, 8'h5A, 8'h00, 3'h0, 7'h00, 1'b0, 1'b1, 16'h0002, 8'h2A);
      run(CSBU_OP_CMP_SKIP, 8'h5A, 8'h5A, 8'h00, 3'h0, 7'h00, 1'b1, 1'b1, 16'h0003, 8'h2A);
      run(CSBU_OP_CMP_SKIP, 8'h5A, 8'h5B, 8'h00, 3'h0, 7'h00, 1'b1, 1'b0, 16'h0001, 8'h2A);
   endtask

   // Value sits only on the source the op names; the other source holds its inverse
   task automatic t_bit_skip();
      logic [7:0] v;
      logic       hit;
      set_flags(8'h11);
      for (int o = 3; o <= 6; o++)
         for (int s = 0; s < 16; s++)
         begin
            v = (s < 8) ? (8'h01 << s[2:0]) : ~(8'h01 << s[2:0]);
            hit = (o == 3 || o == 5) ? ~v[s[2:0]] : v[s[2:0]];
            if (o < 5)
               run(o[3:0], v, 8'h00, ~v, s[2:0], 7'h00, s[0], hit, hit ? (s[0] ? 16'h0003 : 16'h0002) : 16'h0001, 8'h11);
            else
               run(o[3:0], ~v, 8'h00, v, s[2:0], 7'h00, s[0], hit, hit ? (s[0] ? 16'h0003 : 16'h0002) : 16'h0001, 8'h11);
         end
   endtask

   task automatic t_branch();
      logic [7:0]  ft [4] = '{8'h00, 8'hFF, 8'h05, 8'h1A};
      logic [6:0]  off;
      logic [2:0]  s;
      logic        c;
      foreach (ft[f])
      begin
         set_flags(ft[f]);
         for (int o = 7; o <= 14; o++)
         begin
            off = o[0] ? 7'h7E : 7'h05;
            s = 3'(o + f);
            case (o)
               7:  c = ft[f][s];
               8:  c = ~ft[f][s];
               9:  c = ft[f][FLAG_Z];
               10: c = ~ft[f][FLAG_Z];
               11: c = ft[f][FLAG_C];
               12: c = ~ft[f][FLAG_C];
               13: c = ft[f][FLAG_N];
               default: c = ~ft[f][FLAG_N];
            endcase
            run(o[3:0], 8'h00, 8'h00, 8'h00, s, off, 1'b0, c, c ? {{9{off[6]}}, off} + 16'h0001 : 16'h0001, ft[f]);
         end
         run(4'hF, 8'h00, 8'h00, 8'h00, 3'h0, 7'h05, 1'b0, 1'b0, 16'h0001, ft[f]);
      end
   endtask

   // Back-to-back ops read flags written one edge before; a same-cycle outside load must lose
   task automatic t_back_to_back();
      @(posedge clk_i);
      exec_i <= 1'b1;
      op_i <= CSBU_OP_CMP_IMM;
      reg_a_i <= 8'h42;
      reg_b_i <= 8'h42;
      offset_i <= 7'h05;
      next_long_i <= 1'b0;
      flags_load_i <= 8'hFF;
      flags_we_i <= 1'b1;
      @(posedge clk_i);
      flags_we_i <= 1'b0;
      op_i <= CSBU_OP_BR_NE;
      #1;
      exp_pc = exp_pc + PC_STEP_ONE;
      chk("cmp beside load flags", 16'h0002, {8'h00, flags_o});
      chk("cmp beside load pc", exp_pc, pc_o);
      @(posedge clk_i);
      op_i <= CSBU_OP_BR_EQ;
      #1;
      exp_pc = exp_pc + PC_STEP_ONE;
      chk("ne after cmp pc", exp_pc, pc_o);
      chk("ne after cmp taken", 16'h0000, {15'h0000, taken_o});
      @(posedge clk_i);
      exec_i <= 1'b0;
      #1;
      exp_pc = exp_pc + 16'h0006;
      chk("eq after cmp pc", exp_pc, pc_o);
      chk("eq after cmp taken", 16'h0001, {15'h0000, taken_o});
      chk("eq after cmp flags", 16'h0002, {8'h00, flags_o});
   endtask

   // Reset in mid-run beats a pending op and a flags load; an op may follow at once
   task automatic t_mid_reset();
      @(posedge clk_i);
      rst_i <= 1'b1;
      exec_i <= 1'b1;
      op_i <= CSBU_OP_CMP_IMM;
      reg_a_i <= 8'h00;
      reg_b_i <= 8'h01;
      flags_load_i <= 8'hFF;
      flags_we_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      flags_we_i <= 1'b0;
      op_i <= CSBU_OP_SKIP_RBS;
      reg_a_i <= 8'h80;
      bit_sel_i <= 3'h7;
      next_long_i <= 1'b0;
      #1;
      exp_pc = PC_RESET;
      chk("pc mid reset", exp_pc, pc_o);
      chk("flags mid reset", {8'h00, FLAGS_RESET}, {8'h00, flags_o});
      chk("taken mid reset", 16'h0000, {15'h0000, taken_o});
      @(posedge clk_i);
      exec_i <= 1'b0;
      #1;
      exp_pc = exp_pc + PC_STEP_SHORT;
      chk("pc after reset", exp_pc, pc_o);
      chk("taken after reset", 16'h0001, {15'h0000, taken_o});
      chk("flags after reset", {8'h00, FLAGS_RESET}, {8'h00, flags_o});
   endtask

   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   initial
   begin
      repeat (100000) @(posedge clk_i);
      n_mismatch++;
      complete_run();
   end

   initial
   begin
      {rst_i, exec_i, next_long_i, flags_we_i} = 4'h8;
      {op_i, reg_a_i, reg_b_i, io_val_i, flags_load_i, bit_sel_i, offset_i} = '0;
      n_mismatch = 0;
      total_checks = 0;
      exp_pc = PC_RESET;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      t_reset();
      t_cmp_imm();
      t_cmp_skip();
      t_bit_skip();
      t_branch();
      t_back_to_back();
      t_mid_reset();
      complete_run();
   end
endmodule
